// File: common/mpdc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MPDC_REGS_SVH
`define MPDC_REGS_SVH

// ==========================================================================
// Register offsets
`define MPDC_OFS_POWER_CONFIG_FIRST 8'hb0
`define MPDC_OFS_POWER_CONFIG_THIRD 8'hc7
`define MPDC_OFS_SLEEP_STATUS       8'hc8
`define MPDC_OFS_SELECT_CONFIG      8'hc9

// ==========================================================================
// Field positions
`define MPDC_BIT_INACTIVITY_EN      1
`define MPDC_BIT_FAST_MODE_OFF      3
`define MPDC_BIT_FORCE_SLEEP        1
`define MPDC_BIT_SELECT_IN_EN       0
`define MPDC_BIT_STAT_FLAG          0
`define MPDC_BIT_STAT_INACTIVITY    1
`define MPDC_BIT_STAT_FORCED        2
`define MPDC_BIT_STAT_LOGIC_STBY    3
`define MPDC_BIT_STAT_CNT_LO        4

// ==========================================================================
// Reset values
`define MPDC_RST_POWER_CONFIG_FIRST 8'h00
`define MPDC_RST_POWER_CONFIG_THIRD 8'h00
`define MPDC_RST_SELECT_CONFIG      8'h00

// ==========================================================================
// Timing
`define MPDC_REF_CLK_MHZ            40
`define MPDC_INACTIVITY_MAX         4'hf
`define MPDC_IDLE_5V_NS             65
`define MPDC_IDLE_3V3_NS            100
`define MPDC_IDLE_5V_CYC  ((`MPDC_IDLE_5V_NS * `MPDC_REF_CLK_MHZ + 999) / 1000)
`define MPDC_IDLE_3V3_CYC ((`MPDC_IDLE_3V3_NS * `MPDC_REF_CLK_MHZ + 999) / 1000)

`endif

// File: common/mpdc_pkg.sv
// Types of the module power-down control block
package mpdc_pkg;

  typedef enum logic {
    MPDC_RUN,
    MPDC_SLEEP
  } mpdc_sleep_state_t;

  typedef logic [3:0] mpdc_count_t;
  typedef logic [2:0] mpdc_idle_t;

endpackage

// File: src/mpdc_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module mpdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ========================================================================
  // Per-bit synchroniser chains
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate

endmodule

// File: src/mpdc_top.sv
// Module power-down control: inactivity sleep, forced sleep, select gating
`timescale 1ns/1ps
`include "mpdc_regs.svh"

// Operation
// R1: Enabled counter ticks while strobe steady
// R2: Fifteen idle clock periods raise sleep flag
// R3: Strobe transition clears counter, no sleep
// R4: Sleep blocks core address/data input buffers
// R5: Sleep puts memories standby, logic holds
// R6: Wake on strobe, select fall, reset
// R7: Core general ports never affected
// R8: Sleep flag offered to logic bus
// R9: Memory selects gated by sleep flag
// R10: Force bit raises flag at once
// R11: Force bit clears only by reset
// R12: Controller prefetches loop before forcing sleep
// R13: Controller picks slow common clock
// R14: Select input high blocks all memories
// R15: Fast-mode off lets logic idle standby
// R16: Controller adds wait state if needed
// R17: Fast-mode disable resets to zero
// R18: Wake clears flag, restarts counter
module mpdc_top (
  input  wire logic       REF_CLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       ADDR_STROBE_I,
  input  wire logic       COMMON_CLOCK_IN_I,
  input  wire logic       SELECT_IN_N_I,
  input  wire logic       SUPPLY_3V3_I,
  input  wire logic [7:0] LOGIC_IN_I,
  input  wire logic [3:0] ADDR_HIT_I,
  output logic      [3:0] MEM_SELECT_O,
  output logic            POWER_DOWN_FLAG_O,
  output logic            BUS_IN_EN_O,
  output logic            MEM_STANDBY_O,
  output logic            LOGIC_HOLD_O,
  output logic            LOGIC_STANDBY_O,
  output logic            FAST_MODE_OFF_O
);

  // ========================================================================
  // Pin synchronisers
  logic [11:0] pins_s;
  logic        strobe_s;
  logic        cclk_s;
  logic        sel_n_s;
  logic        supply_s;
  logic [7:0]  logic_s;

  mpdc_sync #(
    .WIDTH (12)
  ) u_sync (
    .clk_i    (REF_CLK_I),
    .arst_n_i (ARST_N_I),
    .async_i  ({LOGIC_IN_I, SUPPLY_3V3_I, SELECT_IN_N_I,
                COMMON_CLOCK_IN_I, ADDR_STROBE_I}),
    .sync_o   (pins_s)
  );

  assign strobe_s = pins_s[0];
  assign cclk_s   = pins_s[1];
  assign sel_n_s  = pins_s[2];
  assign supply_s = pins_s[3];
  assign logic_s  = pins_s[11:4];

  // ========================================================================
  // Edge detection on synchronised pins
  logic       strobe_q;
  logic       cclk_q;
  logic       sel_n_q;
  logic [7:0] logic_q;
  logic       strobe_edge;
  logic       cclk_rise;
  logic       sel_fall;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      strobe_q <= 1'b0;
      cclk_q   <= 1'b0;
      sel_n_q  <= 1'b0;
      logic_q  <= 8'h00;
    end else begin
      strobe_q <= strobe_s;
      cclk_q   <= cclk_s;
      sel_n_q  <= sel_n_s;
      logic_q  <= logic_s;
    end
  end

  assign strobe_edge = strobe_s ^ strobe_q;
  assign cclk_rise   = cclk_s & ~cclk_q;
  assign sel_fall    = ~sel_n_s & sel_n_q;

  // ========================================================================
  // Configuration registers and read port
  logic       inactivity_power_down;
  logic       fast_off;
  logic       force_sleep_bit;
  logic       select_in_en;
  logic [7:0] rdata;
  logic       next_inactivity_power_down;
  logic       next_fast_off;
  logic       next_force_sleep_bit;
  logic       next_select_in_en;
  logic [7:0] next_rdata;
  logic       wr_first;
  logic       wr_third;
  logic       force_write;

  mpdc_pkg::mpdc_sleep_state_t state;
  mpdc_pkg::mpdc_count_t       cnt;
  logic                        logic_standby;

  assign wr_first    = WR_I && (ADDR_I == `MPDC_OFS_POWER_CONFIG_FIRST);
  assign wr_third    = WR_I && (ADDR_I == `MPDC_OFS_POWER_CONFIG_THIRD);
  assign force_write = wr_third && WDATA_I[`MPDC_BIT_FORCE_SLEEP];

  always_comb begin
    next_inactivity_power_down = inactivity_power_down;
    next_fast_off              = fast_off;
    next_select_in_en          = select_in_en;
    // Sticky: a zero write does nothing, only reset clears it
    next_force_sleep_bit       = force_sleep_bit | force_write; // R10 R11
    if (wr_first) begin
      next_inactivity_power_down = WDATA_I[`MPDC_BIT_INACTIVITY_EN];
      next_fast_off              = WDATA_I[`MPDC_BIT_FAST_MODE_OFF];
    end
    if (WR_I && (ADDR_I == `MPDC_OFS_SELECT_CONFIG)) begin
      next_select_in_en = WDATA_I[`MPDC_BIT_SELECT_IN_EN];
    end
    next_rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        `MPDC_OFS_POWER_CONFIG_FIRST: begin
          next_rdata[`MPDC_BIT_INACTIVITY_EN] = inactivity_power_down;
          next_rdata[`MPDC_BIT_FAST_MODE_OFF] = fast_off;
        end
        `MPDC_OFS_POWER_CONFIG_THIRD: begin
          next_rdata[`MPDC_BIT_FORCE_SLEEP] = force_sleep_bit;
        end
        `MPDC_OFS_SLEEP_STATUS: begin
          next_rdata[`MPDC_BIT_STAT_FLAG]       = POWER_DOWN_FLAG_O;
          next_rdata[`MPDC_BIT_STAT_INACTIVITY] =
            (state == mpdc_pkg::MPDC_SLEEP);
          next_rdata[`MPDC_BIT_STAT_FORCED]     = force_sleep_bit;
          next_rdata[`MPDC_BIT_STAT_LOGIC_STBY] = logic_standby;
          next_rdata[`MPDC_BIT_STAT_CNT_LO+:4]  = cnt;
        end
        `MPDC_OFS_SELECT_CONFIG: begin
          next_rdata[`MPDC_BIT_SELECT_IN_EN] = select_in_en;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      inactivity_power_down <= 1'b0;
      fast_off              <= 1'b0; // R17
      force_sleep_bit       <= 1'b0;
      select_in_en          <= 1'b0;
      rdata                 <= 8'h00;
    end else begin
      inactivity_power_down <= next_inactivity_power_down;
      fast_off              <= next_fast_off;
      force_sleep_bit       <= next_force_sleep_bit;
      select_in_en          <= next_select_in_en;
      rdata                 <= next_rdata;
    end
  end

  assign RDATA_O = rdata;

  // ========================================================================
  // Inactivity counter and sleep state
  mpdc_pkg::mpdc_sleep_state_t next_state;
  mpdc_pkg::mpdc_count_t       next_cnt;
  logic                        wake;
  logic                        next_flag;

  // Reset release is itself a wake: state leaves reset in RUN
  assign wake = strobe_edge | (select_in_en & sel_fall); // R6

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      mpdc_pkg::MPDC_RUN: begin
        if (strobe_edge || !inactivity_power_down) begin
          next_cnt = 4'h0; // R3
        end else if (cclk_rise) begin
          next_cnt = cnt + 4'h1; // R1
          if (next_cnt == `MPDC_INACTIVITY_MAX) begin
            next_state = mpdc_pkg::MPDC_SLEEP; // R2
          end
        end
      end
      mpdc_pkg::MPDC_SLEEP: begin
        if (wake) begin
          next_state = mpdc_pkg::MPDC_RUN; // R18
          next_cnt   = 4'h0; // R18
        end
      end
    endcase
  end

  // Force overrides the counter and needs no common clock edge
  assign next_flag = (next_state == mpdc_pkg::MPDC_SLEEP) |
                     next_force_sleep_bit; // R10

  // ========================================================================
  // Outputs gated by sleep and select input
  logic [3:0] sel;
  logic [3:0] next_sel;
  logic       flag;
  logic       sel_block;

  // Selects track next_flag so they drop in the same cycle the flag rises
  assign sel_block = next_flag | (select_in_en & sel_n_s); // R9 R14
  assign next_sel  = sel_block ? 4'h0 : ADDR_HIT_I;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= mpdc_pkg::MPDC_RUN;
      cnt   <= 4'h0;
      flag  <= 1'b0;
      sel   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      flag  <= next_flag;
      sel   <= next_sel;
    end
  end

  assign MEM_SELECT_O      = sel;
  assign POWER_DOWN_FLAG_O = flag; // R8
  // Only module-side buffers are gated; core general ports have no path here
  assign BUS_IN_EN_O       = ~flag; // R4 R7
  assign MEM_STANDBY_O     = flag; // R5
  assign LOGIC_HOLD_O      = flag | logic_standby; // R5
  assign FAST_MODE_OFF_O   = fast_off;

  // ========================================================================
  // Logic-array idle standby in non-fast mode
  mpdc_pkg::mpdc_idle_t idle;
  mpdc_pkg::mpdc_idle_t next_idle;
  mpdc_pkg::mpdc_idle_t idle_limit;
  logic                 logic_change;
  logic                 next_logic_standby;

  assign logic_change = (|(logic_s ^ logic_q)) | strobe_edge;
  assign idle_limit   = supply_s ? 3'(`MPDC_IDLE_3V3_CYC)
                                 : 3'(`MPDC_IDLE_5V_CYC);

  always_comb begin
    next_idle = idle;
    if (logic_change) begin
      next_idle = 3'h0;
    end else if (idle != 3'h7) begin
      next_idle = idle + 3'h1;
    end
    next_logic_standby = fast_off & (next_idle >= idle_limit); // R15
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      idle          <= 3'h0;
      logic_standby <= 1'b0;
    end else begin
      idle          <= next_idle;
      logic_standby <= next_logic_standby;
    end
  end

  assign LOGIC_STANDBY_O = logic_standby;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  cnt_tick_a: assert property ( // R1
    state == mpdc_pkg::MPDC_RUN && inactivity_power_down && !strobe_edge
    && cclk_rise && cnt < 4'he |=> cnt == $past(cnt) + 4'h1)
    else $error("inactivity counter did not step");

  sleep_entry_a: assert property ( // R2
    state == mpdc_pkg::MPDC_RUN && inactivity_power_down && !strobe_edge
    && cclk_rise && cnt == 4'he |=> POWER_DOWN_FLAG_O && cnt == 4'hf)
    else $error("no sleep after fifteen idle periods");

  strobe_clear_a: assert property ( // R3
    state == mpdc_pkg::MPDC_RUN && strobe_edge && !force_sleep_bit
    && !force_write |=> cnt == 4'h0 && !POWER_DOWN_FLAG_O)
    else $error("strobe edge did not clear counter");

  bus_block_a: assert property ( // R4
    POWER_DOWN_FLAG_O |-> !BUS_IN_EN_O && MEM_STANDBY_O && LOGIC_HOLD_O)
    else $error("bus or memories active while asleep");

  wake_a: assert property ( // R6
    state == mpdc_pkg::MPDC_SLEEP && wake && !force_sleep_bit
    && !force_write |=> !POWER_DOWN_FLAG_O && cnt == 4'h0)
    else $error("wake event did not end sleep");

  sel_gate_a: assert property ( // R9
    POWER_DOWN_FLAG_O |-> MEM_SELECT_O == 4'h0)
    else $error("memory selected while asleep");

  force_set_a: assert property ( // R10
    force_write |=> POWER_DOWN_FLAG_O && force_sleep_bit)
    else $error("force write did not raise flag");

  force_hold_a: assert property ( // R11
    force_sleep_bit |=> force_sleep_bit [*2])
    else $error("force bit cleared without reset");

  select_block_a: assert property ( // R14
    select_in_en && sel_n_s |=> MEM_SELECT_O == 4'h0)
    else $error("memory selected with select input high");

  idle_stby_a: assert property ( // R15
    (fast_off && !logic_change) [*5] |-> LOGIC_STANDBY_O)
    else $error("logic did not enter idle standby");

  fast_stby_a: assert property ( // R15
    !fast_off |=> !LOGIC_STANDBY_O)
    else $error("standby while fast mode on");

  sleep_entry_c: cover property (
    state == mpdc_pkg::MPDC_RUN ##1 state == mpdc_pkg::MPDC_SLEEP);
  force_c: cover property (force_write ##1 POWER_DOWN_FLAG_O);
  select_wake_c: cover property (
    state == mpdc_pkg::MPDC_SLEEP && select_in_en && sel_fall);
  standby_c: cover property ($rose(LOGIC_STANDBY_O));

endmodule

// File: bench/mpdc_core_model.sv
// Model of the core bus side: address-latch strobe and common clock
`timescale 1ns/1ps

module mpdc_core_model (
  input  wire logic clk_i,
  output logic      addr_strobe_o,
  output logic      common_clock_o
);
  // ========================================================================
  // Pin state
  initial begin
    addr_strobe_o  = 1'b0;
    common_clock_o = 1'b0;
  end

  // ========================================================================
  // Common clock pulses, eight reference cycles each
  // Slow enough that normal strobe traffic always fits inside 15 pulses
  task automatic tick(input int n);
    @(posedge clk_i);
    repeat (n) begin
      common_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      common_clock_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  // One strobe edge, as the core makes on a bus cycle
  task automatic toggle();
    @(posedge clk_i);
    addr_strobe_o <= ~addr_strobe_o;
  endtask
endmodule

// File: bench/tb_mpdc_top.sv
// Self-checking testbench of the module power-down control block
`timescale 1ns/1ps
`include "mpdc_regs.svh"

module tb_mpdc_top;
  logic       ref_clk;
  logic       arst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       addr_strobe;
  logic       common_clock;
  logic       select_in_n;
  logic       supply_3v3;
  logic [7:0] logic_in;
  logic [3:0] addr_hit;
  logic [3:0] mem_select;
  logic       flag;
  logic       bus_in_en;
  logic       mem_standby;
  logic       logic_hold;
  logic       logic_standby;
  logic       fast_off;
  int         bad_count;
  int         comparisons;
  logic [7:0] got;

  mpdc_top dut (
    .REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ADDR_STROBE_I(addr_strobe),
    .COMMON_CLOCK_IN_I(common_clock), .SELECT_IN_N_I(select_in_n),
    .SUPPLY_3V3_I(supply_3v3), .LOGIC_IN_I(logic_in), .ADDR_HIT_I(addr_hit),
    .MEM_SELECT_O(mem_select), .POWER_DOWN_FLAG_O(flag),
    .BUS_IN_EN_O(bus_in_en), .MEM_STANDBY_O(mem_standby),
    .LOGIC_HOLD_O(logic_hold), .LOGIC_STANDBY_O(logic_standby),
    .FAST_MODE_OFF_O(fast_off)
  );

  mpdc_core_model core (
    .clk_i(ref_clk), .addr_strobe_o(addr_strobe),
    .common_clock_o(common_clock)
  );

  // ========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(2);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ========================================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  // ========================================================================
  // Tests
  initial begin
    bad_count = 0; comparisons = 0;
    arst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    select_in_n = 1'b0; supply_3v3 = 1'b0; logic_in = 8'h00;
    addr_hit = 4'hf;
    do_reset();
    // Reset state and unmapped places
    rd_reg(8'hb0, got); check(got, 8'h00);
    check({7'h00, fast_off}, 8'h00);
    check({7'h00, bus_in_en}, 8'h01);
    check({4'h0, mem_select}, 8'h0f);
    wr_reg(8'h55, 8'hff);
    rd_reg(8'h55, got); check(got, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'h00);
    // Inactivity sleep after exactly fifteen periods
    wr_reg(8'hb0, 8'h02);
    rd_reg(8'hb0, got); check(got, 8'h02);
    cyc(1); check(rdata, 8'h00);
    core.tick(14); cyc(8);
    check({7'h00, flag}, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'he0);
    core.tick(1); cyc(6);
    check({7'h00, flag}, 8'h01);
    check({7'h00, bus_in_en}, 8'h00);
    check({6'h00, mem_standby, logic_hold}, 8'h03);
    check({4'h0, mem_select}, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'hf3);
    // Strobe resumes: wake and restart
    core.toggle(); cyc(6);
    check({7'h00, flag}, 8'h00);
    check({3'h0, bus_in_en, mem_select}, 8'h1f);
    rd_reg(8'hc8, got); check(got, 8'h00);
    // Strobe edge before the count ends clears it
    core.tick(10); core.toggle(); cyc(4); core.tick(10); cyc(8);
    check({7'h00, flag}, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'ha0);
    // Select input gating and select-fall wake
    wr_reg(8'hc9, 8'h01);
    @(posedge ref_clk) select_in_n <= 1'b1;
    cyc(5); check({4'h0, mem_select}, 8'h00);
    core.toggle(); cyc(4); core.tick(15); cyc(6);
    check({7'h00, flag}, 8'h01);
    @(posedge ref_clk) select_in_n <= 1'b0;
    cyc(6); check({7'h00, flag}, 8'h00);
    check({4'h0, mem_select}, 8'h0f);
    // Forced sleep, sticky until reset; strobe and select fall do not wake it
    wr_reg(8'hb0, 8'h00);
    wr_reg(8'hc7, 8'h02); check({7'h00, flag}, 8'h01);
    check({4'h0, mem_select}, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'h05);
    core.toggle(); cyc(6); check({7'h00, flag}, 8'h01);
    @(posedge ref_clk) select_in_n <= 1'b1;
    cyc(4);
    @(posedge ref_clk) select_in_n <= 1'b0;
    cyc(6); check({7'h00, flag}, 8'h01);
    wr_reg(8'hc7, 8'h00); cyc(2); check({7'h00, flag}, 8'h01);
    do_reset(); check({7'h00, flag}, 8'h00);
    rd_reg(8'hc8, got); check(got, 8'h00);
    // Logic idle standby with fast mode off, both supplies
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk) supply_3v3 <= s[0];
      wr_reg(8'hb0, 8'h08); check({7'h00, fast_off}, 8'h01);
      cyc(10);
      check({6'h00, logic_standby, logic_hold}, 8'h03);
      rd_reg(8'hc8, got); check(got, 8'h08);
      @(posedge ref_clk) logic_in <= ~logic_in;
      cyc(4); check({7'h00, logic_standby}, 8'h00);
      // Idle limit is 3 cycles at 5V, 4 cycles at 3.3V
      cyc(1); check({7'h00, logic_standby}, 8'h00);
      cyc(1); check({7'h00, logic_standby}, {7'h00, ~s[0]});
      cyc(1); check({7'h00, logic_standby}, 8'h01);
      wr_reg(8'hb0, 8'h00); check({7'h00, fast_off}, 8'h00);
    end
    finish_test();
  end
endmodule
